/* smpf_defines.svh */
/*
  Constants of the serial monitor-and-control packet framer: frame layout,
  command and tag codes, error codes and timing counts.
  Assumes a 250 MHz system clock and is included by its bare name.
*/
`ifndef SMPF_DEFINES_SVH
`define SMPF_DEFINES_SVH

// ****************************************
// Frame layout
// ****************************************
`define SMPF_SYNC_HI        8'haa
`define SMPF_SYNC_LO        8'h55
`define SMPF_BCAST_ADDR     8'hff
`define SMPF_DATA_MIN       6
`define SMPF_DATA_MAX       32
`define SMPF_PREAMBLE_LEN   6
`define SMPF_PKT_MAX        64
`define SMPF_HDR_LEN        4

// ****************************************
// Command, tag and error codes
// ****************************************
`define SMPF_CMD_SET_REQ    8'h00
`define SMPF_CMD_GET_REQ    8'h01
`define SMPF_CMD_SET_RSP    8'h02
`define SMPF_CMD_GET_RSP    8'h03
`define SMPF_TAG_SETTINGS   8'h00
`define SMPF_TAG_THRESH     8'h01
`define SMPF_TAG_RESERVED   8'h02
`define SMPF_TAG_COND       8'h03
`define SMPF_TAG_ADC        8'h04
`define SMPF_ERR_NONE       8'h00
`define SMPF_ERR_TOO_BIG    8'h01
`define SMPF_ERR_NO_DATA    8'h02
`define SMPF_ERR_BAD_VALUE  8'h03
`define SMPF_ERR_READ_ONLY  8'h04
`define SMPF_ERR_BAD_CSUM   8'h05
`define SMPF_ERR_UNKNOWN    8'h06

// ****************************************
// Serial character and timing
// ****************************************
`define SMPF_CHAR_DATA_BITS 8
`define SMPF_CHAR_STOP_BITS 1
`define SMPF_CLK_MHZ        250
`define SMPF_GAP_CHARS      5
`define SMPF_LINK_TMO_MS    1000
`define SMPF_LINK_TMO_CYC   (`SMPF_LINK_TMO_MS * `SMPF_CLK_MHZ * 1000)
`define SMPF_SW_TMO_US      100
`define SMPF_SW_TMO_CYC     (`SMPF_SW_TMO_US * `SMPF_CLK_MHZ)

`endif

/* smpf_framer.sv */
/*
  Packet framer for the binary monitor-and-control serial protocol: receives
  bytes from a UART, validates and decodes request frames, and sends response
  frames byte by byte. Also handles amplifier-link and RF switch faults.
  Assumes a UART outside this block (8N1, baud set by the panel) that hands
  received bytes as one-cycle strobes and accepts bytes on a valid/ready pair.
  The payload store and resource data live outside; this block reads payload
  bytes for responses through a small index/data port.
*/
`timescale 1ns/1ps
`include "smpf_defines.svh"

module smpf_framer #(
  parameter int LINK_TMO_CYC = `SMPF_LINK_TMO_CYC,
  parameter int SW_TMO_CYC   = `SMPF_SW_TMO_CYC,
  parameter int NUM_ALARMS   = 8,
  parameter int NUM_SWITCHES = 2
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Configuration
  input  wire logic [7:0]              own_addr,
  input  wire logic                    redundant_mode,
  // Received bytes from the UART
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_byte,
  // Bytes to the UART
  output logic                         tx_valid,
  output logic [7:0]                   tx_byte,
  input  wire logic                    tx_ready,
  // Decoded request
  output logic                         req_strobe,
  output logic                         req_is_set,
  output logic [7:0]                   req_tag,
  output logic [7:0]                   req_addr,
  output logic [7:0]                   req_len,
  output logic                         payload_we,
  output logic [4:0]                   payload_idx,
  output logic [7:0]                   payload_byte,
  output logic                         thresh_commit,
  // Response payload source
  output logic [4:0]                   rsp_idx,
  input  wire logic [7:0]              rsp_byte,
  input  wire logic [4:0]              rsp_len,
  // Amplifier link and alarms
  input  wire logic                    amp_reply_ok,
  input  wire logic [NUM_ALARMS-1:0]   alarm_in,
  input  wire logic                    summary_in,
  output logic [NUM_ALARMS-1:0]        alarm_out,
  output logic                         summary_out,
  output logic                         no_connection,
  // RF switches
  input  wire logic [NUM_SWITCHES-1:0] sw_pos_a,
  input  wire logic [NUM_SWITCHES-1:0] sw_pos_b,
  output logic [NUM_SWITCHES-1:0]      sw_position,
  output logic                         sw_fault
);
  import smpf_pkg::*;

  // Counters need at least two states; bytes must match the character width
  if (NUM_ALARMS < 1 || NUM_SWITCHES < 1 || LINK_TMO_CYC < 2 || SW_TMO_CYC < 2 ||
      $bits(rx_byte) != `SMPF_CHAR_DATA_BITS) begin : g_param_check
    $error("smpf_framer: unsupported parameter values");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] min_len(input logic [7:0] tag);
    case (tag)
      `SMPF_TAG_THRESH, `SMPF_TAG_ADC: min_len = 8'h02;
      default:                         min_len = 8'h01;
    endcase
  endfunction

  function automatic logic tag_known(input logic [7:0] tag);
    tag_known = (tag == `SMPF_TAG_SETTINGS) || (tag == `SMPF_TAG_THRESH) ||
                (tag == `SMPF_TAG_COND) || (tag == `SMPF_TAG_ADC);
  endfunction

  // ****************************************
  // Receive state machine
  // ****************************************
  smpf_rx_state_type rx_state_r;
  logic [7:0]        csum_r;
  logic [5:0]        cnt_r;
  logic [5:0]        data_cnt_r;
  logic [7:0]        pre_r [0:5];
  logic [7:0]        src_r;
  logic              bcast_r;
  logic [6:0]        pkt_len_r;
  logic [7:0]        err_r;
  logic              start_rsp_r;

  wire logic [7:0] r_cmd  = pre_r[2];
  wire logic [7:0] r_tag  = pre_r[3];
  wire logic [7:0] r_dlen = pre_r[5];
  wire logic       too_long = (pkt_len_r >= 7'(`SMPF_PKT_MAX));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_state_r  <= SMPF_RX_SYNC_HI;
      csum_r      <= 8'h00;
      cnt_r       <= 6'h00;
      data_cnt_r  <= 6'h00;
      src_r       <= 8'h00;
      bcast_r     <= 1'b0;
      pkt_len_r   <= 7'h00;
      err_r       <= 8'h00;
      start_rsp_r <= 1'b0;
      for (int i = 0; i < 6; i++) pre_r[i] <= 8'h00;
    end else begin
      start_rsp_r <= 1'b0;
      if (rx_valid) begin
        pkt_len_r <= pkt_len_r + 7'h01;
        case (rx_state_r)
          SMPF_RX_SYNC_HI: begin
            pkt_len_r <= 7'h01;
            if (rx_byte == `SMPF_SYNC_HI) rx_state_r <= SMPF_RX_SYNC_LO;
          end
          SMPF_RX_SYNC_LO: begin
            if (rx_byte == `SMPF_SYNC_LO) rx_state_r <= SMPF_RX_DEST;
            else if (rx_byte != `SMPF_SYNC_HI) rx_state_r <= SMPF_RX_SYNC_HI;
          end
          SMPF_RX_DEST: begin
            csum_r  <= rx_byte;
            bcast_r <= (rx_byte == `SMPF_BCAST_ADDR);
            if (rx_byte == own_addr || rx_byte == `SMPF_BCAST_ADDR) begin
              rx_state_r <= SMPF_RX_SRC;
            end else begin
              rx_state_r <= SMPF_RX_SYNC_HI;
            end
          end
          SMPF_RX_SRC: begin
            csum_r     <= csum_r + rx_byte;
            src_r      <= rx_byte;
            cnt_r      <= 6'h00;
            // A broadcast source address is not a valid node
            rx_state_r <= (rx_byte == `SMPF_BCAST_ADDR) ? SMPF_RX_SYNC_HI : SMPF_RX_PRE;
          end
          SMPF_RX_PRE: begin
            csum_r           <= csum_r + rx_byte;
            pre_r[cnt_r[2:0]] <= rx_byte;
            cnt_r            <= cnt_r + 6'h01;
            data_cnt_r       <= 6'h00;
            if (cnt_r == 6'(`SMPF_PREAMBLE_LEN - 1)) begin
              // Payload length follows the data length byte only on sets
              if (pre_r[2] == `SMPF_CMD_SET_REQ && rx_byte != 8'h00) begin
                rx_state_r <= SMPF_RX_DATA;
              end else begin
                rx_state_r <= SMPF_RX_CSUM;
              end
              if (pre_r[2] > `SMPF_CMD_GET_REQ) rx_state_r <= SMPF_RX_SYNC_HI;
            end
          end
          SMPF_RX_DATA: begin
            csum_r     <= csum_r + rx_byte;
            data_cnt_r <= data_cnt_r + 6'h01;
            if (too_long) begin
              rx_state_r <= SMPF_RX_SYNC_HI;
            end else if (data_cnt_r + 6'h01 == 6'(r_dlen)) begin
              rx_state_r <= SMPF_RX_CSUM;
            end
          end
          SMPF_RX_CSUM: begin
            rx_state_r  <= SMPF_RX_SYNC_HI;
            start_rsp_r <= 1'b1;
            if (rx_byte != csum_r)                          err_r <= `SMPF_ERR_BAD_CSUM;
            else if (r_dlen > 8'(`SMPF_DATA_MAX - `SMPF_PREAMBLE_LEN))
                                                            err_r <= `SMPF_ERR_TOO_BIG;
            else if (!tag_known(r_tag))                     err_r <= `SMPF_ERR_NO_DATA;
            else if (r_cmd == `SMPF_CMD_SET_REQ &&
                     (r_tag == `SMPF_TAG_COND || r_tag == `SMPF_TAG_ADC))
                                                            err_r <= `SMPF_ERR_READ_ONLY;
            else if (r_dlen < min_len(r_tag))               err_r <= `SMPF_ERR_BAD_VALUE;
            else                                            err_r <= `SMPF_ERR_NONE;
          end
          default: rx_state_r <= SMPF_RX_SYNC_HI;
        endcase
      end
    end
  end

  // ****************************************
  // Decoded request outputs
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      payload_we   <= 1'b0;
      payload_idx  <= 5'h00;
      payload_byte <= 8'h00;
    end else begin
      payload_we <= rx_valid && rx_state_r == SMPF_RX_DATA && !too_long;
      if (rx_valid) begin
        payload_idx  <= data_cnt_r[4:0];
        payload_byte <= rx_byte;
      end
    end
  end

  // Request only acted on once the checksum and checks passed
  wire logic rx_good = start_rsp_r && err_r == `SMPF_ERR_NONE;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_strobe    <= 1'b0;
      req_is_set    <= 1'b0;
      req_tag       <= 8'h00;
      req_addr      <= 8'h00;
      req_len       <= 8'h00;
      thresh_commit <= 1'b0;
    end else begin
      req_strobe    <= rx_good;
      thresh_commit <= rx_good && r_cmd == `SMPF_CMD_SET_REQ && r_tag == `SMPF_TAG_THRESH;
      if (rx_good) begin
        req_is_set <= (r_cmd == `SMPF_CMD_SET_REQ);
        req_tag    <= r_tag;
        req_addr   <= pre_r[4];
        req_len    <= r_dlen;
      end
    end
  end

  // ****************************************
  // Response sender
  // ****************************************
  smpf_tx_state_type tx_state_r;
  logic [5:0]        tx_pos_r;
  logic [7:0]        tx_csum_r;
  logic [4:0]        tx_plen_r;
  logic [7:0]        tx_byte_nxt;

  wire logic [5:0] tx_last = 6'(`SMPF_HDR_LEN + `SMPF_PREAMBLE_LEN) + 6'(tx_plen_r);

  // Byte at each frame position; errors carry no payload
  always_comb begin
    case (tx_pos_r)
      6'd0:    tx_byte_nxt = `SMPF_SYNC_HI;
      6'd1:    tx_byte_nxt = `SMPF_SYNC_LO;
      6'd2:    tx_byte_nxt = src_r;
      6'd3:    tx_byte_nxt = own_addr;
      6'd4:    tx_byte_nxt = pre_r[0];
      6'd5:    tx_byte_nxt = pre_r[1];
      6'd6:    tx_byte_nxt = r_cmd + 8'h02;
      6'd7:    tx_byte_nxt = r_tag;
      6'd8:    tx_byte_nxt = err_r;
      6'd9:    tx_byte_nxt = 8'(tx_plen_r);
      default: tx_byte_nxt = (tx_pos_r == tx_last) ? tx_csum_r : rsp_byte;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_state_r <= SMPF_TX_IDLE;
      tx_pos_r   <= 6'h00;
      tx_csum_r  <= 8'h00;
      tx_plen_r  <= 5'h00;
      tx_valid   <= 1'b0;
      tx_byte    <= 8'h00;
      rsp_idx    <= 5'h00;
    end else begin
      case (tx_state_r)
        SMPF_TX_IDLE: begin
          tx_pos_r  <= 6'h00;
          tx_csum_r <= 8'h00;
          // Only complete frames reach here, so noise gets no answer
          if (start_rsp_r) begin
            tx_plen_r  <= (err_r == `SMPF_ERR_NONE && r_cmd == `SMPF_CMD_GET_REQ) ?
                          rsp_len : 5'h00;
            tx_state_r <= SMPF_TX_SEND;
          end
        end
        SMPF_TX_SEND: begin
          tx_valid   <= 1'b1;
          tx_byte    <= tx_byte_nxt;
          if (tx_pos_r >= 6'd2 && tx_pos_r != tx_last) tx_csum_r <= tx_csum_r + tx_byte_nxt;
          rsp_idx    <= 5'(tx_pos_r - 6'd9);
          tx_state_r <= SMPF_TX_WAIT;
        end
        SMPF_TX_WAIT: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_pos_r == tx_last) begin
              tx_state_r <= SMPF_TX_IDLE;
            end else begin
              tx_pos_r   <= tx_pos_r + 6'h01;
              tx_state_r <= SMPF_TX_SEND;
            end
          end
        end
        default: tx_state_r <= SMPF_TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Amplifier link supervision
  // ****************************************
  // A full silence timeout, not a single missed reply, to avoid chattering
  logic [$clog2(LINK_TMO_CYC+1)-1:0] link_cnt_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link_cnt_r    <= '0;
      no_connection <= 1'b1;
    end else if (amp_reply_ok) begin
      link_cnt_r    <= '0;
      no_connection <= 1'b0;
    end else if (link_cnt_r == ($bits(link_cnt_r))'(LINK_TMO_CYC - 1)) begin
      no_connection <= 1'b1;
    end else begin
      link_cnt_r <= link_cnt_r + 1'b1;
    end
  end

  // Last amplifier values stay with their owner; only alarms are overridden
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      alarm_out   <= '1;
      summary_out <= 1'b1;
    end else begin
      alarm_out   <= no_connection ? '1 : alarm_in;
      summary_out <= no_connection | summary_in;
    end
  end

  // ****************************************
  // RF switch tracking
  // ****************************************
  // A switch showing both or neither contact for too long is undetermined
  logic [$clog2(SW_TMO_CYC+1)-1:0] sw_cnt_r [NUM_SWITCHES];
  logic [NUM_SWITCHES-1:0]         sw_bad_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sw_position <= '0;
      sw_bad_r    <= '0;
      for (int i = 0; i < NUM_SWITCHES; i++) sw_cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_SWITCHES; i++) begin
        if (sw_pos_a[i] ^ sw_pos_b[i]) begin
          sw_position[i] <= sw_pos_b[i];
          sw_cnt_r[i]    <= '0;
          sw_bad_r[i]    <= 1'b0;
        end else if (sw_cnt_r[i] == ($bits(sw_cnt_r[i]))'(SW_TMO_CYC - 1)) begin
          sw_bad_r[i] <= 1'b1;
        end else begin
          sw_cnt_r[i] <= sw_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) sw_fault <= 1'b0;
    else       sw_fault <= redundant_mode && |sw_bad_r;
  end

endmodule

/* smpf_framer_properties.sv */
/*
  Port checker for the packet framer.
  Assumes it is bound into smpf_framer and shares its parameters.
*/
`timescale 1ns/1ps
`include "smpf_defines.svh"
module smpf_framer_properties #(
  parameter int LINK_TMO_CYC = 50,
  parameter int NUM_ALARMS   = 8
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  nrst,
  // Watched ports
  input wire logic                  tx_valid,
  input wire logic [7:0]            tx_byte,
  input wire logic                  tx_ready,
  input wire logic                  req_strobe,
  input wire logic                  req_is_set,
  input wire logic [7:0]            req_tag,
  input wire logic                  thresh_commit,
  input wire logic                  amp_reply_ok,
  input wire logic [NUM_ALARMS-1:0] alarm_in,
  input wire logic                  summary_in,
  input wire logic [NUM_ALARMS-1:0] alarm_out,
  input wire logic                  summary_out,
  input wire logic                  no_connection
);
  logic [15:0] quiet_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Cycles since the last amplifier reply; saturates so a dead link stays flagged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      quiet_r <= 16'h0;
    end else if (amp_reply_ok) begin
      quiet_r <= 16'h0;
    end else if (quiet_r != 16'hffff) begin
      quiet_r <= quiet_r + 16'h1;
    end
  end
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_taken;
    tx_valid && tx_ready;
  endsequence
  chk_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_byte))
    else $error("tx byte changed while stalled");
  chk_tx_gap: assert property (s_taken |=> !tx_valid)
    else $error("tx valid not dropped after a byte");
  chk_req_pulse: assert property (req_strobe |=> !req_strobe)
    else $error("request strobe longer than one cycle");
  chk_commit_tie: assert property (thresh_commit |-> req_strobe && req_is_set
    && req_tag == `SMPF_TAG_THRESH)
    else $error("threshold commit without threshold set");
  chk_rsp_start: assert property (req_strobe && !tx_valid |=> tx_valid
    && tx_byte == `SMPF_SYNC_HI)
    else $error("response does not start with sync");
  chk_link_lost: assert property (quiet_r > LINK_TMO_CYC + 2 |-> no_connection)
    else $error("link loss not flagged");
  chk_link_back: assert property (amp_reply_ok |-> ##[1:3] !no_connection)
    else $error("no-connection not cleared");
  chk_alarm_force: assert property (no_connection && $past(no_connection)
    |-> alarm_out == '1 && summary_out)
    else $error("alarms not forced on link loss");
  chk_alarm_pass: assert property (!no_connection && !$past(no_connection)
    |-> alarm_out == $past(alarm_in) && summary_out == $past(summary_in))
    else $error("alarms do not follow amplifier");
endmodule
bind smpf_framer smpf_framer_properties #(
  .LINK_TMO_CYC(LINK_TMO_CYC),
  .NUM_ALARMS(NUM_ALARMS)
) u_props (.clock, .nrst, .tx_valid, .tx_byte, .tx_ready, .req_strobe, .req_is_set,
  .req_tag, .thresh_commit, .amp_reply_ok, .alarm_in, .summary_in, .alarm_out,
  .summary_out, .no_connection);

/* smpf_host_model.sv */
/*
  Host computer model: sends request bytes and takes response bytes.
  Assumes one-cycle receive strobes and a valid/ready send side.
*/
`timescale 1ns/1ps
module smpf_host_model (
  // Clock and test control
  input  wire logic       clock,
  input  wire logic       stall,
  // Request bytes
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  // Response bytes
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h0;
    tx_ready = 1'b0;
  end
  // A slow host drops ready at random
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte);
    end
    #1 tx_ready = stall ? 1'($urandom_range(0, 1)) : 1'b1;
  end
  // Released line shows the inverse so a stale byte is never reread
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clock);
      #1 rx_valid = 1'b1;
      rx_byte = f[i];
      @(posedge clock);
      #1 rx_valid = 1'b0;
      rx_byte = ~f[i];
    end
    repeat (60) @(posedge clock);
  endtask
endmodule

/* smpf_pkg.sv */
/*
  Types of the packet framer: the receive and send state machines.
  Assumes the constants header is included where numbers are needed.
*/
package smpf_pkg;

  typedef enum logic [3:0] {
    SMPF_RX_SYNC_HI,
    SMPF_RX_SYNC_LO,
    SMPF_RX_DEST,
    SMPF_RX_SRC,
    SMPF_RX_PRE,
    SMPF_RX_DATA,
    SMPF_RX_CSUM,
    SMPF_RX_DISCARD
  } smpf_rx_state_type;

  typedef enum logic [2:0] {
    SMPF_TX_IDLE,
    SMPF_TX_SEND,
    SMPF_TX_WAIT
  } smpf_tx_state_type;

endpackage

/* test_serial_mc_packet_framer.sv */
/*
  Testbench of the packet framer: requests from a host model, checked responses.
  Assumes smpf_framer, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "smpf_defines.svh"
module test_serial_mc_packet_framer;
  logic       clock = 1'b0, nrst = 1'b0, redundant_mode = 1'b0, amp_reply_ok = 1'b0;
  logic       summary_in = 1'b0, stall = 1'b0, amp_on = 1'b0;
  logic       rx_valid, tx_valid, tx_ready, req_strobe, req_is_set, payload_we;
  logic       thresh_commit, summary_out, no_connection, sw_fault;
  logic [7:0] own_addr = 8'h0, alarm_in = 8'h0, rx_byte, tx_byte, req_tag, req_addr;
  logic [7:0] req_len, payload_byte, rsp_byte, alarm_out, f[$], e[$];
  logic [4:0] rsp_len = 5'h0, payload_idx, rsp_idx;
  logic [1:0] sw_pos_a = 2'h0, sw_pos_b = 2'h0, sw_position;
  int         mismatches = 0, checked = 0, we_cnt, tc_cnt;
  assign rsp_byte = {3'h0, rsp_idx} ^ 8'ha5;
  smpf_framer #(.LINK_TMO_CYC(50), .SW_TMO_CYC(20)) dut (.clock, .nrst, .own_addr,
    .redundant_mode, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .req_strobe,
    .req_is_set, .req_tag, .req_addr, .req_len, .payload_we, .payload_idx, .payload_byte,
    .thresh_commit, .rsp_idx, .rsp_byte, .rsp_len, .amp_reply_ok, .alarm_in, .summary_in,
    .alarm_out, .summary_out, .no_connection, .sw_pos_a, .sw_pos_b, .sw_position, .sw_fault);
  smpf_host_model host (.clock, .stall, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready);
  always #2 clock = ~clock;
  always begin
    repeat (10) @(posedge clock);
    #1 amp_reply_ok = amp_on;
    @(posedge clock);
    #1 amp_reply_ok = 1'b0;
  end
  always @(posedge clock) begin
    we_cnt += int'(payload_we === 1'b1);
    tc_cnt += int'(thresh_commit === 1'b1);
    if (payload_we === 1'b1) check(payload_byte, f[10 + payload_idx], "payload byte");
  end
  task automatic check(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] sum(input logic [7:0] q[$]);
    logic [7:0] a = 8'h0;
    for (int i = 2; i < q.size(); i++) a += q[i];
    return a;
  endfunction
  function automatic logic [7:0] err_of(input logic [7:0] c, t, n, input bit bad);
    if (bad) return `SMPF_ERR_BAD_CSUM;
    if (n > 26) return `SMPF_ERR_TOO_BIG;
    if (t == `SMPF_TAG_RESERVED || t > `SMPF_TAG_ADC) return `SMPF_ERR_NO_DATA;
    if (c == `SMPF_CMD_SET_REQ && t >= `SMPF_TAG_COND) return `SMPF_ERR_READ_ONLY;
    if (n < ((t == `SMPF_TAG_THRESH || t == `SMPF_TAG_ADC) ? 2 : 1)) return `SMPF_ERR_BAD_VALUE;
    return `SMPF_ERR_NONE;
  endfunction
  // bad: 1 breaks the checksum, 2 breaks the sync word
  task automatic run(input logic [7:0] d, s, c, t, n, input logic [1:0] bad);
    logic [7:0] er, pl;
    bit ok;
    f = {8'haa, 8'h55, d, s, 8'h00, 8'($urandom), c, t, 8'($urandom_range(0, 9)), n};
    if (c == 0) repeat (n) f.push_back(8'($urandom));
    f.push_back(sum(f) ^ {7'h0, bad == 1});
    if (bad == 2) f[1] = 8'h54;
    ok = (d == own_addr || d == `SMPF_BCAST_ADDR) && s != 8'hff && c <= 1 && bad != 2;
    er = err_of(c, t, n, bad == 1);
    pl = (er == 0 && c == 1) ? {3'h0, rsp_len} : 8'h0;
    e = {8'haa, 8'h55, s, own_addr, f[4], f[5], c + 8'h2, t, er, pl};
    for (int i = 0; i < pl; i++) e.push_back({3'h0, i[4:0]} ^ 8'ha5);
    e.push_back(sum(e));
    host.got.delete();
    we_cnt = 0;
    tc_cnt = 0;
    host.send(f);
    #1;
    if (!ok) begin
      check(host.got.size(), 0, "silent");
      return;
    end
    for (int i = 0; i < 600 && host.got.size() < e.size(); i++) @(posedge clock);
    #1;
    check(host.got.size(), e.size(), "rsp size");
    foreach (e[i]) check(host.got[i], e[i], "rsp byte");
    if (er == 0) begin
      check(req_tag, t, "tag");
      check(req_is_set, c == 0, "cmd");
      check(req_len, n, "len");
      check(req_addr, f[8], "addr");
      check(we_cnt, c == 0 ? n : 0, "payload");
      check(tc_cnt, c == 0 && t == 1, "commit");
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h5ef67065));
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    own_addr = 8'($urandom_range(0, 254));
    alarm_in = 8'($urandom);
    summary_in = 1'b1;
    amp_on = 1'b1;
    check(no_connection, 1, "reset link");
    repeat (20) @(posedge clock);
    #1 check(no_connection, 0, "link up");
    rsp_len = 5'h3;
    run(own_addr, 8'h10, 1, 0, 4, 0);
    run(8'hff, 8'h11, 1, 1, 2, 0);
    run(own_addr ^ 8'h1, 8'h12, 1, 0, 1, 0);
    run(own_addr, 8'hff, 1, 0, 1, 0);
    run(own_addr, 8'h13, 2, 0, 1, 0);
    run(own_addr, 8'h14, 3, 0, 1, 0);
    run(own_addr, 8'h15, 1, 0, 1, 2);
    run(own_addr, 8'h16, 0, 1, 2, 0);
    run(own_addr, 8'h17, 0, 3, 1, 0);
    run(own_addr, 8'h18, 0, 4, 2, 0);
    run(own_addr, 8'h19, 1, 2, 1, 0);
    run(own_addr, 8'h1a, 0, 0, 27, 0);
    run(own_addr, 8'h1b, 1, 4, 1, 0);
    run(own_addr, 8'h1c, 1, 0, 3, 1);
    repeat (24) begin
      stall = 1'($urandom_range(0, 1));
      rsp_len = 5'($urandom_range(0, 8));
      run($urandom_range(0, 3) == 0 ? 8'hff : own_addr, 8'($urandom_range(0, 254)),
        8'($urandom_range(0, 1)), 8'($urandom_range(0, 4)), 8'($urandom_range(0, 28)),
        2'($urandom_range(0, 7) == 0));
    end
    summary_in = 1'b0;
    amp_on = 1'b0;
    repeat (80) @(posedge clock);
    #1 check(no_connection, 1, "link lost");
    check({alarm_out, summary_out}, 9'h1ff, "alarms forced");
    amp_on = 1'b1;
    repeat (20) @(posedge clock);
    #1 check(no_connection, 0, "link back");
    check({alarm_out, summary_out}, {alarm_in, 1'b0}, "alarms follow");
    check(sw_fault, 0, "switch fault masked");
    redundant_mode = 1'b1;
    sw_pos_a = 2'b01;
    sw_pos_b = 2'b10;
    repeat (5) @(posedge clock);
    #1 check({sw_position, sw_fault}, 3'b100, "switch pos");
    sw_pos_a = 2'b11;
    repeat (40) @(posedge clock);
    #1 check({sw_position, sw_fault}, 3'b101, "switch fault");
    finish_test();
  end
endmodule
